// ---- rtl/dsd_ctrl.sv ----
/*
 Control side of two sigma-delta converters: register port, mode control,
 calibration coefficient storage, rate selection, decimation and chopping.
 Assumes modulator bitstreams synchronous to MCLK and a factory gain word
 that is valid whenever reset is released.
*/
// Summary of operation
// - the auxiliary gain coefficient is 16 bits held as a low and a high byte register.
// - after reset the gain bytes take the per-device factory value, not a constant.
// - an internal or system full-scale calibration overwrites the gain bytes with its result.
// - software coefficient writes only land while all three mode bits are zero.
// - the primary converter has eight input ranges chosen by a range field.
// - the primary channel field picks pairs one/two, three/four, three/two or two shorted.
// - the auxiliary channel field picks inputs three, four, five or the temperature sensor.
// - after a channel change no new word is flagged until the converter has settled.
// - an eight-bit decimation word sets the output rate of both converters.
// - the output period runs from about 10.21 ms at the smallest word to 186.77 ms at 0xFF.
// - each converter decimates its bitstream with a third-order sinc filter.
// - inputs are chopped between phases so the converter offset cancels.
// - a single or first continuous result takes two output periods.
// - calibration runs with the decimation word forced to 0xFF, the user word kept.
// - unipolar results are straight binary, bipolar ones offset binary.
`timescale 1ns/1ps
`include "dsd_defs.svh"
module dsd_ctrl #(
	parameter logic [31:0] STEP_CYC = `DSD_STEP_CYC,
	parameter int ACC_W = 80
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic SRST,
	// register port
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	// factory trim
	input wire logic [15:0] FACTORY_GAIN,
	// modulator bitstreams
	input wire logic PRI_MOD_BIT,
	input wire logic AUX_MOD_BIT,
	// analog front end control
	output dsd_pkg::dsd_range_t PRI_RANGE,
	output dsd_pkg::dsd_pri_chan_e PRI_CHAN,
	output dsd_pkg::dsd_aux_chan_e AUX_CHAN,
	output logic PRI_CHOP,
	output logic AUX_CHOP,
	// conversion results
	output logic [15:0] PRI_RESULT,
	output logic PRI_READY,
	output logic [15:0] AUX_RESULT,
	output logic AUX_READY
);
	import dsd_pkg::*;

	dsd_mode_e mode;
	logic [7:0] pri_ctrl, aux_ctrl, rate;
	logic [7:0] gain_lo, gain_hi;
	logic fac_loaded;
	logic run, cal, full_cal;
	logic [7:0] rate_eff, rate_eff_q;
	logic [31:0] dec_n;
	dsd_pri_chan_e pri_chan_q;
	dsd_aux_chan_e aux_chan_q;
	logic pri_restart, aux_restart;
	logic [15:0] pri_raw, aux_raw;
	logic pri_raw_valid, aux_raw_valid;
	logic coef_wr_ok;

	// mode decode
	always_comb
	begin
		unique case (mode)
			MODE_OFF, MODE_IDLE:
			begin
				run = 1'b0;
				cal = 1'b0;
			end
			MODE_SINGLE, MODE_CONT:
			begin
				run = 1'b1;
				cal = 1'b0;
			end
			MODE_ZERO_INT, MODE_FULL_INT, MODE_ZERO_SYS, MODE_FULL_SYS:
			begin
				run = 1'b1;
				cal = 1'b1;
			end
		endcase
		full_cal = (mode == MODE_FULL_INT) || (mode == MODE_FULL_SYS);
		coef_wr_ok = (mode == MODE_OFF);
	end

	// effective decimation word and count
	always_comb
	begin
		if (cal)
			rate_eff = `DSD_RATE_CAL;
		else if (rate < `DSD_RATE_MIN)
			rate_eff = `DSD_RATE_MIN;
		else
			rate_eff = rate;
		dec_n = ({24'h000000, rate_eff} + 32'h00000001) * STEP_CYC;
	end

	// mode register; hardware returns it to off when a run ends
	always_ff @(posedge MCLK)
	begin
		if (SRST)
			mode <= dsd_mode_e'(`DSD_MODE_RST);
		else if (SFR_WR && SFR_ADDR == `DSD_OFF_MODE)
			mode <= dsd_mode_e'(SFR_WDATA[2:0]);
		else if ((mode == MODE_SINGLE && PRI_READY) || (cal && AUX_READY))
			mode <= MODE_OFF;
	end

	// control and rate registers
	always_ff @(posedge MCLK)
	begin
		if (SRST)
		begin
			pri_ctrl <= `DSD_CTRL_RST;
			aux_ctrl <= `DSD_CTRL_RST;
			rate <= `DSD_RATE_RST;
		end
		else if (SFR_WR)
		begin
			if (SFR_ADDR == `DSD_OFF_PRI_CTRL)
				pri_ctrl <= SFR_WDATA;
			if (SFR_ADDR == `DSD_OFF_AUX_CTRL)
				aux_ctrl <= SFR_WDATA;
			if (SFR_ADDR == `DSD_OFF_RATE)
				rate <= SFR_WDATA;
		end
	end

	// auxiliary gain coefficient bytes
	always_ff @(posedge MCLK)
	begin
		if (SRST)
		begin
			gain_lo <= 8'(`DSD_GAIN_RST);
			gain_hi <= 8'(`DSD_GAIN_RST >> 8);
			fac_loaded <= 1'b0;
		end
		else if (!fac_loaded)
		begin
			gain_lo <= FACTORY_GAIN[7:0];
			gain_hi <= FACTORY_GAIN[15:8];
			fac_loaded <= 1'b1;
		end
		else if (full_cal && AUX_READY)
		begin
			gain_lo <= AUX_RESULT[7:0];
			gain_hi <= AUX_RESULT[15:8];
		end
		else if (SFR_WR && coef_wr_ok)
		begin
			if (SFR_ADDR == `DSD_OFF_GAIN_LO)
				gain_lo <= SFR_WDATA;
			if (SFR_ADDR == `DSD_OFF_GAIN_HI)
				gain_hi <= SFR_WDATA;
		end
	end

	// front end selection straight from the control fields
	always_comb
	begin
		PRI_RANGE = pri_ctrl[`DSD_RANGE_LSB +: 3];
		PRI_CHAN = dsd_pri_chan_e'(pri_ctrl[`DSD_CHAN_LSB +: 2]);
		AUX_CHAN = dsd_aux_chan_e'(aux_ctrl[`DSD_CHAN_LSB +: 2]);
	end

	// restart on stop, channel change or rate change
	always_ff @(posedge MCLK)
	begin
		if (SRST)
		begin
			pri_chan_q <= PCH_ONE_TWO;
			aux_chan_q <= ACH_THREE;
			rate_eff_q <= `DSD_RATE_RST;
		end
		else
		begin
			pri_chan_q <= PRI_CHAN;
			aux_chan_q <= AUX_CHAN;
			rate_eff_q <= rate_eff;
		end
	end

	always_comb
	begin
		pri_restart = !run || (PRI_CHAN != pri_chan_q) || (rate_eff != rate_eff_q);
		aux_restart = !run || (AUX_CHAN != aux_chan_q) || (rate_eff != rate_eff_q);
	end

	// decimators see the bitstream with the chop swap undone
	dsd_sinc3 #(.ACC_W(ACC_W), .CNT_W(32)) u_pri_sinc (
		.clk(MCLK),
		.rst(SRST),
		.restart(pri_restart),
		.dec_n(dec_n),
		.bit_in(PRI_MOD_BIT ^ PRI_CHOP),
		.raw(pri_raw),
		.raw_valid(pri_raw_valid)
	);

	dsd_sinc3 #(.ACC_W(ACC_W), .CNT_W(32)) u_aux_sinc (
		.clk(MCLK),
		.rst(SRST),
		.restart(aux_restart),
		.dec_n(dec_n),
		.bit_in(AUX_MOD_BIT ^ AUX_CHOP),
		.raw(aux_raw),
		.raw_valid(aux_raw_valid)
	);

	dsd_chop u_pri_chop (
		.clk(MCLK),
		.rst(SRST),
		.restart(pri_restart),
		.unipolar(pri_ctrl[`DSD_UNI_BIT]),
		.phase_valid(pri_raw_valid),
		.phase_raw(pri_raw),
		.chop_pol(PRI_CHOP),
		.result(PRI_RESULT),
		.result_valid(PRI_READY)
	);

	dsd_chop u_aux_chop (
		.clk(MCLK),
		.rst(SRST),
		.restart(aux_restart),
		.unipolar(aux_ctrl[`DSD_UNI_BIT]),
		.phase_valid(aux_raw_valid),
		.phase_raw(aux_raw),
		.chop_pol(AUX_CHOP),
		.result(AUX_RESULT),
		.result_valid(AUX_READY)
	);

	// registered read data; unmapped offsets read zero
	always_ff @(posedge MCLK)
	begin
		if (SRST)
			SFR_RDATA <= 8'h00;
		else if (SFR_RD)
		begin
			unique case (SFR_ADDR)
				`DSD_OFF_GAIN_LO: SFR_RDATA <= gain_lo;
				`DSD_OFF_GAIN_HI: SFR_RDATA <= gain_hi;
				`DSD_OFF_MODE: SFR_RDATA <= {5'h00, mode};
				`DSD_OFF_PRI_CTRL: SFR_RDATA <= pri_ctrl;
				`DSD_OFF_AUX_CTRL: SFR_RDATA <= aux_ctrl;
				`DSD_OFF_RATE: SFR_RDATA <= rate; // user word, even mid-calibration
				`DSD_OFF_PRI_RES_HI: SFR_RDATA <= PRI_RESULT[15:8];
				`DSD_OFF_PRI_RES_LO: SFR_RDATA <= PRI_RESULT[7:0];
				`DSD_OFF_AUX_RES_HI: SFR_RDATA <= AUX_RESULT[15:8];
				`DSD_OFF_AUX_RES_LO: SFR_RDATA <= AUX_RESULT[7:0];
				default: SFR_RDATA <= 8'h00;
			endcase
		end
	end

	// checks
	sequence s_coef_wr_blocked;
		SFR_WR && (SFR_ADDR == `DSD_OFF_GAIN_LO) && mode != MODE_OFF && fac_loaded;
	endsequence

	sequence s_coef_wr_open;
		SFR_WR && (SFR_ADDR == `DSD_OFF_GAIN_HI) && mode == MODE_OFF && fac_loaded;
	endsequence

	sequence s_pri_chan_change;
		run && (PRI_CHAN != pri_chan_q);
	endsequence

	property p_coef_ignored;
		@(posedge MCLK) disable iff (SRST)
		s_coef_wr_blocked and !(full_cal && AUX_READY) |=> $stable(gain_lo);
	endproperty
	a_coef_ignored: assert property (p_coef_ignored)
		else $error("gain byte changed by a write outside mode zero");

	property p_coef_taken;
		@(posedge MCLK) disable iff (SRST)
		s_coef_wr_open |=> gain_hi == $past(SFR_WDATA);
	endproperty
	a_coef_taken: assert property (p_coef_taken)
		else $error("gain byte write in mode zero not stored");

	property p_cal_gain;
		@(posedge MCLK) disable iff (SRST)
		full_cal && AUX_READY |=> {gain_hi, gain_lo} == $past(AUX_RESULT) && mode == MODE_OFF;
	endproperty
	a_cal_gain: assert property (p_cal_gain)
		else $error("full-scale calibration did not update gain");

	property p_factory;
		@(posedge MCLK) disable iff (SRST)
		$rose(fac_loaded) |-> {gain_hi, gain_lo} == $past(FACTORY_GAIN);
	endproperty
	a_factory: assert property (p_factory)
		else $error("factory gain not loaded after reset");

	property p_cal_rate;
		@(posedge MCLK) disable iff (SRST)
		cal |-> rate_eff == `DSD_RATE_CAL && dec_n == 32'd256 * STEP_CYC;
	endproperty
	a_cal_rate: assert property (p_cal_rate)
		else $error("calibration not run at the largest decimation word");

	property p_rate_restore;
		@(posedge MCLK) disable iff (SRST)
		$fell(cal) && rate >= `DSD_RATE_MIN |-> rate_eff == rate;
	endproperty
	a_rate_restore: assert property (p_rate_restore)
		else $error("user decimation word not restored after calibration");

	property p_settle;
		@(posedge MCLK) disable iff (SRST)
		s_pri_chan_change |-> !PRI_READY [*8];
	endproperty
	a_settle: assert property (p_settle)
		else $error("result flagged right after a channel change");

	property p_single_end;
		@(posedge MCLK) disable iff (SRST)
		mode == MODE_SINGLE && PRI_READY && !SFR_WR |=> mode == MODE_OFF ##1 !PRI_READY;
	endproperty
	a_single_end: assert property (p_single_end)
		else $error("single conversion did not stop after its word");

	property p_chop_flip;
		@(posedge MCLK) disable iff (SRST)
		pri_raw_valid && !pri_restart |=> PRI_CHOP != $past(PRI_CHOP);
	endproperty
	a_chop_flip: assert property (p_chop_flip)
		else $error("chop polarity did not alternate");
endmodule

// ---- rtl/dsd_defs.svh ----
/*
 Register offsets, field positions, reset values and timing counts of the
 dual sigma-delta converter control block. Assumes an 8-bit register port.
*/
`ifndef DSD_DEFS_SVH
`define DSD_DEFS_SVH

// register offsets
`define DSD_OFF_GAIN_LO 8'hEC
`define DSD_OFF_GAIN_HI 8'hED
`define DSD_OFF_MODE 8'hB1
`define DSD_OFF_PRI_CTRL 8'hB2
`define DSD_OFF_AUX_CTRL 8'hB3
`define DSD_OFF_RATE 8'hB4
`define DSD_OFF_PRI_RES_HI 8'hB5
`define DSD_OFF_PRI_RES_LO 8'hB6
`define DSD_OFF_AUX_RES_HI 8'hB7
`define DSD_OFF_AUX_RES_LO 8'hB8

// field positions in the control registers
`define DSD_RANGE_LSB 0
`define DSD_CHAN_LSB 4
`define DSD_UNI_BIT 6

// reset values
`define DSD_MODE_RST 3'h0
`define DSD_CTRL_RST 8'h00
`define DSD_RATE_RST 8'h45
`define DSD_GAIN_RST 16'h0000

// decimation words
`define DSD_RATE_CAL 8'hFF
`define DSD_RATE_MIN 8'h0D

// timing: longest output period in us, clock in MHz
`define DSD_TMAX_US 186770
`define DSD_TMIN_US 9520
`define DSD_CLK_MHZ 100
`define DSD_TMAX_CYC (`DSD_TMAX_US * `DSD_CLK_MHZ)
`define DSD_STEP_CYC (`DSD_TMAX_CYC / 256)

`endif

// ---- rtl/dsd_pkg.sv ----
/*
 Types shared by the converter control block: converter modes and channel
 selections. Assumes nothing beyond a SystemVerilog compiler.
*/
package dsd_pkg;

	// converter mode bits
	typedef enum logic [2:0] {
		MODE_OFF = 3'b000,
		MODE_IDLE = 3'b001,
		MODE_SINGLE = 3'b010,
		MODE_CONT = 3'b011,
		MODE_ZERO_INT = 3'b100,
		MODE_FULL_INT = 3'b101,
		MODE_ZERO_SYS = 3'b110,
		MODE_FULL_SYS = 3'b111
	} dsd_mode_e;

	// primary differential pair
	typedef enum logic [1:0] {
		PCH_ONE_TWO = 2'b00,
		PCH_THREE_FOUR = 2'b01,
		PCH_THREE_TWO = 2'b10,
		PCH_TWO_TWO = 2'b11
	} dsd_pri_chan_e;

	// auxiliary single-ended source
	typedef enum logic [1:0] {
		ACH_THREE = 2'b00,
		ACH_FOUR = 2'b01,
		ACH_FIVE = 2'b10,
		ACH_TEMP = 2'b11
	} dsd_aux_chan_e;

	typedef logic [2:0] dsd_range_t;

endpackage

// ---- rtl/dsd_sinc3.sv ----
/*
 Third-order sinc decimator for one modulator bitstream. Assumes one
 modulator bit per clock and a decimation count of at least two.
*/
`timescale 1ns/1ps
module dsd_sinc3 #(
	parameter int ACC_W = 80,
	parameter int CNT_W = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic restart,
	input wire logic [CNT_W-1:0] dec_n,
	// bitstream in
	input wire logic bit_in,
	// phase result out
	output logic [15:0] raw,
	output logic raw_valid
);
	logic [CNT_W-1:0] cnt;
	logic [ACC_W-1:0] i1, i2, i3, n1, n2, n3, wide, dn, fs;
	int sh;

	// index of the highest set bit
	function automatic int flog2(input logic [ACC_W-1:0] v);
		int r;
		r = 0;
		for (int k = 0; k < ACC_W; k++)
			if (v[k])
				r = k;
		return r;
	endfunction

	// integrator inputs including this sample; a full-density stream is
	// scaled to at least 2^16 so it saturates to all ones
	always_comb
	begin
		n1 = i1 + {{(ACC_W-1){1'b0}}, bit_in};
		n2 = i2 + n1;
		n3 = i3 + n2;
		dn = ACC_W'(dec_n);
		fs = dn * (dn + ACC_W'(1)) * (dn + ACC_W'(2)) / ACC_W'(6);
		sh = flog2(fs) - 16;
		wide = (sh >= 0) ? (n3 >> sh) : (n3 << (-sh));
	end

	// three cascaded integrators dumped every dec_n samples
	always_ff @(posedge clk)
	begin
		if (rst || restart)
		begin
			cnt <= '0;
			i1 <= '0;
			i2 <= '0;
			i3 <= '0;
			raw_valid <= 1'b0;
		end
		else if (cnt == dec_n - 1'b1)
		begin
			cnt <= '0;
			i1 <= '0;
			i2 <= '0;
			i3 <= '0;
			raw_valid <= 1'b1;
		end
		else
		begin
			cnt <= cnt + 1'b1;
			i1 <= n1;
			i2 <= n2;
			i3 <= n3;
			raw_valid <= 1'b0;
		end
	end

	// normalised, saturated phase result
	always_ff @(posedge clk)
	begin
		if (rst)
			raw <= 16'h0000;
		else if (!restart && cnt == dec_n - 1'b1)
			raw <= (|wide[ACC_W-1:16]) ? 16'hFFFF : wide[15:0];
	end
endmodule

// ---- rtl/dsd_chop.sv ----
/*
 Chopping sequencer and output coding for one converter. Assumes phase
 results arrive at most once per decimation period.
*/
`timescale 1ns/1ps
module dsd_chop (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic restart,
	input wire logic unipolar,
	// phase results from the decimator
	input wire logic phase_valid,
	input wire logic [15:0] phase_raw,
	// input swap to the analog mux
	output logic chop_pol,
	// conversion word
	output logic [15:0] result,
	output logic result_valid
);
	logic [15:0] prev;
	logic [16:0] sum;
	logic [15:0] avg;
	logic seen;

	// averaging swapped phases cancels the offset
	always_comb
	begin
		sum = {1'b0, prev} + {1'b0, phase_raw};
		avg = sum[16:1];
	end

	// polarity flips every phase; first word needs two phases
	always_ff @(posedge clk)
	begin
		if (rst || restart)
		begin
			chop_pol <= 1'b0;
			seen <= 1'b0;
			prev <= 16'h0000;
			result_valid <= 1'b0;
		end
		else
		begin
			result_valid <= phase_valid && seen;
			if (phase_valid)
			begin
				chop_pol <= ~chop_pol;
				prev <= phase_raw;
				seen <= 1'b1;
			end
		end
	end

	// straight binary when unipolar, offset binary when bipolar
	always_ff @(posedge clk)
	begin
		if (rst)
			result <= 16'h0000;
		else if (phase_valid && seen && !restart)
		begin
			if (!unipolar)
				result <= avg;
			else if (!avg[15])
				result <= 16'h0000;
			else
				result <= {avg[14:0], &avg[14:0]};
		end
	end
endmodule

// ---- verif/dsd_sensor.sv ----
/*
 Behavioural model of the sensors on the converter inputs: an ideal
 modulator per converter that turns the selected channel's level into a
 bitstream. Assumes the bench sets one full-scale or zero level per channel.
*/
`timescale 1ns/1ps
module dsd_sensor (
	// clock
	input wire logic clk,
	// channel picked by the front end control
	input wire logic [1:0] chan,
	// input swap level from the front end control
	input wire logic chop,
	// per-channel level, one for full scale, zero for zero scale
	input wire logic [3:0] lvl,
	// modulator bitstream
	output logic mod_bit
);
	// the mux swap inverts the modulator stream at once, so the block's
	// undo with its own chop level gives back the source level every bit
	always_comb
	begin
		mod_bit = lvl[chan] ^ chop;
	end
endmodule

// ---- verif/test_dsd_ctrl.sv ----
/*
 Self-checking bench of the converter control block with two sensor models.
 Assumes a short rate step so conversions take under a hundred clocks and calibrations about a thousand.
*/
`timescale 1ns/1ps
`include "dsd_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_dsd_ctrl;
	import dsd_pkg::*;
	localparam logic [31:0] STEP = 32'h2;
	localparam logic [15:0] TRIM = 16'h5A3C;
	logic MCLK = 1'b0, SRST = 1'b1, SFR_WR = 1'b0, SFR_RD = 1'b0;
	logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA, rd;
	logic [15:0] PRI_RESULT, AUX_RESULT;
	logic PRI_MOD_BIT, AUX_MOD_BIT, PRI_CHOP, AUX_CHOP, PRI_READY, AUX_READY;
	logic [3:0] pri_lvl = 4'hF, aux_lvl = 4'h0;
	dsd_range_t PRI_RANGE;
	dsd_pri_chan_e PRI_CHAN;
	dsd_aux_chan_e AUX_CHAN;
	int n_fail = 0, samples_checked = 0, cyc = 0, n, chops = 0;
	logic last_chop = 1'b0;
	dsd_ctrl #(.STEP_CYC(STEP), .ACC_W(80)) dsd_ctrl_i (.MCLK(MCLK), .SRST(SRST),
		.SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA),
		.SFR_RDATA(SFR_RDATA), .FACTORY_GAIN(TRIM), .PRI_MOD_BIT(PRI_MOD_BIT),
		.AUX_MOD_BIT(AUX_MOD_BIT), .PRI_RANGE(PRI_RANGE), .PRI_CHAN(PRI_CHAN),
		.AUX_CHAN(AUX_CHAN), .PRI_CHOP(PRI_CHOP), .AUX_CHOP(AUX_CHOP),
		.PRI_RESULT(PRI_RESULT), .PRI_READY(PRI_READY), .AUX_RESULT(AUX_RESULT),
		.AUX_READY(AUX_READY));
	dsd_sensor pri_sensor_i (.clk(MCLK), .chan(PRI_CHAN), .chop(PRI_CHOP), .lvl(pri_lvl),
		.mod_bit(PRI_MOD_BIT));
	dsd_sensor aux_sensor_i (.clk(MCLK), .chan(AUX_CHAN), .chop(AUX_CHOP), .lvl(aux_lvl),
		.mod_bit(AUX_MOD_BIT));
	// clock
	initial
	begin
		forever #5 MCLK = ~MCLK;
	end
	// hang guard and chop activity count
	always @(posedge MCLK)
	begin
		cyc++;
		if (PRI_CHOP !== last_chop) chops++;
		last_chop = PRI_CHOP;
		if (cyc == 20000)
		begin
			n_fail++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one register write, strobe held for one edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge MCLK);
		SFR_ADDR <= a;
		SFR_WDATA <= d;
		SFR_WR <= 1'b1;
		@(posedge MCLK);
		SFR_WR <= 1'b0;
		#1;
	endtask
	// one register read, data taken the cycle after the strobe
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge MCLK);
		SFR_ADDR <= a;
		SFR_RD <= 1'b1;
		@(posedge MCLK);
		SFR_RD <= 1'b0;
		#1 rd = SFR_RDATA;
		`CHK(rd, e)
	endtask
	// cycles until a ready pulse, bounded
	task automatic wait_rdy(input bit aux, input int lim);
		n = 0;
		do
		begin
			@(posedge MCLK);
			#1 n++;
		end while (!(aux ? AUX_READY : PRI_READY) && n < lim);
		`CHK(aux ? AUX_READY : PRI_READY, 1'b1)
	endtask
	// reset values, factory trim and unmapped offset
	task automatic t_reset();
		rdchk(`DSD_OFF_MODE, 8'h00);
		rdchk(`DSD_OFF_RATE, 8'h45);
		rdchk(`DSD_OFF_PRI_CTRL, 8'h00);
		rdchk(`DSD_OFF_PRI_RES_HI, 8'h00);
		rdchk(`DSD_OFF_GAIN_LO, TRIM[7:0]);
		rdchk(`DSD_OFF_GAIN_HI, TRIM[15:8]);
		rdchk(8'h00, 8'h00);
	endtask
	// coefficient writes land only with all mode bits clear
	task automatic t_gain();
		wr(`DSD_OFF_GAIN_LO, 8'h34);
		wr(`DSD_OFF_GAIN_HI, 8'h12);
		rdchk(`DSD_OFF_GAIN_LO, 8'h34);
		rdchk(`DSD_OFF_GAIN_HI, 8'h12);
		wr(`DSD_OFF_MODE, 8'h01);
		wr(`DSD_OFF_GAIN_LO, 8'hFF);
		wr(`DSD_OFF_GAIN_HI, 8'hEE);
		rdchk(`DSD_OFF_GAIN_LO, 8'h34);
		rdchk(`DSD_OFF_GAIN_HI, 8'h12);
		wr(`DSD_OFF_MODE, 8'h00);
	endtask
	// single conversion: two phases, then the mode falls back to off
	task automatic t_single(input logic [7:0] rate, input int eff, input logic [15:0] e);
		wr(`DSD_OFF_RATE, rate);
		wr(`DSD_OFF_MODE, 8'h02);
		wait_rdy(1'b0, 4000);
		`CHK(n >= 2 * (eff + 1) * STEP - 2, 1'b1)
		`CHK(n <= 2 * (eff + 1) * STEP + 8, 1'b1)
		`CHK(PRI_RESULT, e)
		rdchk(`DSD_OFF_MODE, 8'h00);
	endtask
	// every range and channel code, with coding checked per channel
	task automatic t_fields();
		for (int r = 0; r < 8; r++)
		begin
			wr(`DSD_OFF_PRI_CTRL, 8'(r));
			`CHK(PRI_RANGE, dsd_range_t'(r))
		end
		@(posedge MCLK);
		pri_lvl <= 4'b0101;
		for (int c = 0; c < 4; c++)
		begin
			wr(`DSD_OFF_PRI_CTRL, 8'h40 | 8'(c << 4));
			wr(`DSD_OFF_AUX_CTRL, 8'(c << 4));
			`CHK(PRI_CHAN, dsd_pri_chan_e'(c))
			`CHK(AUX_CHAN, dsd_aux_chan_e'(c))
			t_single(8'h0D, 13, (c % 2 == 0) ? 16'hFFFF : 16'h0000);
		end
		`CHK(chops > 0, 1'b1)
	endtask
	// channel change in continuous mode restarts the two-phase wait
	task automatic t_switch();
		wr(`DSD_OFF_PRI_CTRL, 8'h00);
		wr(`DSD_OFF_MODE, 8'h03);
		wait_rdy(1'b0, 200);
		`CHK(PRI_RESULT, 16'hFFFF)
		wr(`DSD_OFF_PRI_CTRL, 8'h10);
		wait_rdy(1'b0, 200);
		`CHK(n >= 2 * 14 * STEP - 8, 1'b1)
		`CHK(PRI_RESULT, 16'h0000)
		wr(`DSD_OFF_MODE, 8'h00);
	endtask
	// full-scale calibration at the forced rate stores its result
	task automatic t_cal(input logic [7:0] m);
		@(posedge MCLK);
		aux_lvl <= (m == 8'h05) ? 4'h0 : 4'hF;
		wr(`DSD_OFF_MODE, m);
		wait_rdy(1'b1, 1400);
		`CHK(n >= 2 * 256 * STEP - 2, 1'b1)
		@(posedge MCLK);
		rdchk(`DSD_OFF_GAIN_LO, (m == 8'h05) ? 8'h00 : 8'hFF);
		rdchk(`DSD_OFF_GAIN_HI, (m == 8'h05) ? 8'h00 : 8'hFF);
		rdchk(`DSD_OFF_RATE, 8'h0D);
		rdchk(`DSD_OFF_MODE, 8'h00);
	endtask
	// main sequence
	initial
	begin
		repeat (16) @(posedge MCLK);
		SRST <= 1'b0;
		repeat (2) @(posedge MCLK);
		t_reset();
		t_gain();
		t_single(8'h00, 13, 16'hFFFF);
		t_fields();
		t_switch();
		t_cal(8'h05);
		t_cal(8'h07);
		complete_run();
	end
endmodule
